// ===== verilog/oscreg_pkg.sv
// Package for the oscillator identification and device-control register bank.
// Assumes a byte-wide register port in the single core clock domain.
`default_nettype none

package oscreg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PRODUCT_IDENTIFIER   = 8'h02;
  localparam logic [7:0] OFS_MASK_REVISION        = 8'h03;
  localparam logic [7:0] OFS_SERIAL_SLAVE_ADDRESS = 8'h08;
  localparam logic [7:0] OFS_IMAGE_REVISION       = 8'h09;
  localparam logic [7:0] OFS_DEVICE_CONTROL       = 8'h0A;
  localparam logic [7:0] OFS_SOFTWARE_RESET       = 8'h48;

  // ----------------------------------------------------------------
  // Identity values (arbitrary neutral values)
  // ----------------------------------------------------------------
  localparam logic [7:0] PRODUCT_ID_VALUE         = 8'hA5;
  localparam logic [7:0] MASK_REV_VALUE           = 8'h01;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         DC_PLL_POWER_DOWN_BIT    = 6;
  localparam int         DC_CAL_TRIGGER_BIT       = 1;
  localparam int         DC_AUTO_START_BIT        = 0;
  localparam int         SW_RESET_BIT             = 1;
  localparam logic [3:0] DC_SPARE_RESET           = 4'h0;
  localparam logic       DC_PLL_POWER_DOWN_RESET  = 1'b0;
  localparam logic       DC_AUTO_START_RESET      = 1'b1;
  localparam logic [7:0] IMAGE_REVISION_RESET     = 8'h00;
  localparam logic [6:0] SLAVE_ADDRESS_RESET      = 7'h58;
  localparam logic [1:0] ADDR_LOW_PIN_LOW         = 2'h0;
  localparam logic [1:0] ADDR_LOW_PIN_FLOAT       = 2'h1;
  localparam logic [1:0] ADDR_LOW_PIN_HIGH        = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } oscreg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } oscreg_rsp_t;

  typedef enum logic [2:0] {
    ST_CONFIG,
    ST_HALT,
    ST_CAL,
    ST_LOCK,
    ST_RUN,
    ST_POWER_DOWN
  } oscreg_state_t;

endpackage : oscreg_pkg

`default_nettype wire

// ===== verilog/oscreg_top.sv
// Identification, slave address, image revision and device-control registers.
// Assumes a serial engine drives byte requests on core_clk; NVM and PLL status
// arrive from same-clock logic, reset and address pins come from outside.
`timescale 1ns/1ps
`default_nettype none

module oscreg_top
  import oscreg_pkg::*;
(
  // Clock and power-on reset
  input  wire  logic          core_clk,
  input  wire  logic          sys_rst,
  // Device pins
  input  wire  logic          reset_pin_n,
  input  wire  logic          addr_pin_high,
  input  wire  logic          addr_pin_float,
  // Register port
  input  wire  oscreg_req_t   reg_req,
  output var   oscreg_rsp_t   reg_rsp,
  // Non-volatile memory
  input  wire  logic [4:0]    nvm_slave_addr_hi,
  input  wire  logic [7:0]    nvm_image_rev,
  input  wire  logic          nvm_commit_done,
  // PLL
  input  wire  logic          pll_cal_done,
  input  wire  logic          pll_locked,
  output logic                pll_enable,
  output logic                pll_reset,
  output logic                cal_start,
  output logic                outputs_enable
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree
  logic [2:0] rst_pin_sync_reg;
  logic [2:0] hi_sync_reg;
  logic [2:0] fl_sync_reg;
  logic       rst_pin_n_reg;
  logic       addr_hi_reg;
  logic       addr_fl_reg;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_pin_sync_reg <= 3'h7;
      hi_sync_reg      <= 3'h0;
      fl_sync_reg      <= 3'h0;
    end else begin
      rst_pin_sync_reg <= {rst_pin_sync_reg[1:0], reset_pin_n};
      hi_sync_reg      <= {hi_sync_reg[1:0], addr_pin_high};
      fl_sync_reg      <= {fl_sync_reg[1:0], addr_pin_float};
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_pin_n_reg <= 1'b1;
      addr_hi_reg   <= 1'b0;
      addr_fl_reg   <= 1'b0;
    end else begin
      if (rst_pin_sync_reg[1] == rst_pin_sync_reg[2]) begin
        rst_pin_n_reg <= rst_pin_sync_reg[2];
      end
      if (hi_sync_reg[1] == hi_sync_reg[2]) begin
        addr_hi_reg <= hi_sync_reg[2];
      end
      if (fl_sync_reg[1] == fl_sync_reg[2]) begin
        addr_fl_reg <= fl_sync_reg[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Device reset
  // ----------------------------------------------------------------
  logic dc_wr;
  logic sw_rst_wr;
  logic dev_rst;

  assign dc_wr     = reg_req.wr && (reg_req.addr == OFS_DEVICE_CONTROL);
  assign sw_rst_wr = reg_req.wr && (reg_req.addr == OFS_SOFTWARE_RESET)
                     && reg_req.wdata[SW_RESET_BIT];
  assign dev_rst   = !rst_pin_n_reg || sw_rst_wr;

  // ----------------------------------------------------------------
  // Device control register
  // ----------------------------------------------------------------
  // Control bits other than the calibration trigger survive a device reset other than power-on
  logic       pll_power_down_reg;
  logic       auto_start_reg;
  logic       cal_trigger_reg;
  logic [3:0] dc_spare_reg;
  logic       cal_rise;

  assign cal_rise = dc_wr && reg_req.wdata[DC_CAL_TRIGGER_BIT] && !cal_trigger_reg;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pll_power_down_reg <= DC_PLL_POWER_DOWN_RESET;
      auto_start_reg     <= DC_AUTO_START_RESET;
      dc_spare_reg       <= DC_SPARE_RESET;
    end else if (dc_wr) begin
      pll_power_down_reg <= reg_req.wdata[DC_PLL_POWER_DOWN_BIT];
      auto_start_reg     <= reg_req.wdata[DC_AUTO_START_BIT];
      dc_spare_reg       <= reg_req.wdata[5:2];
    end
  end

  // Set beats done in one cycle so a fresh launch is not lost
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cal_trigger_reg <= 1'b0;
    end else if (dev_rst) begin
      cal_trigger_reg <= 1'b0;
    end else if (cal_rise) begin
      cal_trigger_reg <= 1'b1;
    end else if (pll_cal_done) begin
      cal_trigger_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Loaded values
  // ----------------------------------------------------------------
  logic [4:0] slave_hi_reg;
  logic [1:0] slave_lo_reg;
  logic [7:0] image_rev_reg;
  logic       load_now;
  logic [1:0] pin_code;
  oscreg_state_t state_reg;

  assign load_now = (state_reg == ST_CONFIG);

  always_comb begin
    if (addr_fl_reg) begin
      pin_code = ADDR_LOW_PIN_FLOAT;
    end else if (addr_hi_reg) begin
      pin_code = ADDR_LOW_PIN_HIGH;
    end else begin
      pin_code = ADDR_LOW_PIN_LOW;
    end
  end

  // Pin sampled during configuration only, like a strap
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      slave_hi_reg <= SLAVE_ADDRESS_RESET[6:2];
      slave_lo_reg <= SLAVE_ADDRESS_RESET[1:0];
    end else if (load_now) begin
      slave_hi_reg <= nvm_slave_addr_hi;
      slave_lo_reg <= pin_code;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      image_rev_reg <= IMAGE_REVISION_RESET;
    end else if (load_now || nvm_commit_done) begin
      image_rev_reg <= nvm_image_rev;
    end
  end

  // ----------------------------------------------------------------
  // Start-up sequencer
  // ----------------------------------------------------------------
  // Power-down is taken from the stored bit, so clearing it
  // restarts calibration one cycle after the write lands
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_CONFIG;
    end else if (dev_rst) begin
      state_reg <= ST_CONFIG;
    end else if (pll_power_down_reg) begin
      state_reg <= ST_POWER_DOWN;
    end else begin
      case (state_reg)
        ST_CONFIG: begin
          state_reg <= auto_start_reg ? ST_CAL : ST_HALT;
        end
        ST_HALT: begin
          if (dc_wr && reg_req.wdata[DC_AUTO_START_BIT]) begin
            state_reg <= ST_CAL;
          end
        end
        ST_CAL: begin
          if (pll_cal_done) begin
            state_reg <= ST_LOCK;
          end
        end
        ST_LOCK: begin
          if (pll_locked) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (cal_rise) begin
            state_reg <= ST_CAL;
          end
        end
        ST_POWER_DOWN: state_reg <= ST_CAL;
        default:       state_reg <= ST_CONFIG;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // PLL controls
  // ----------------------------------------------------------------
  logic cal_entry;

  assign cal_entry = !dev_rst && !pll_power_down_reg &&
                     (((state_reg == ST_CONFIG) && auto_start_reg) ||
                      ((state_reg == ST_HALT) && dc_wr && reg_req.wdata[DC_AUTO_START_BIT]) ||
                      (state_reg == ST_POWER_DOWN) ||
                      ((state_reg == ST_RUN) && cal_rise));

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cal_start <= 1'b0;
    end else begin
      cal_start <= cal_entry;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pll_enable     <= 1'b0;
      pll_reset      <= 1'b1;
      outputs_enable <= 1'b0;
    end else begin
      pll_enable     <= !pll_power_down_reg && !dev_rst &&
                        (cal_entry || (state_reg == ST_CAL) ||
                         (state_reg == ST_LOCK) || (state_reg == ST_RUN));
      pll_reset      <= pll_power_down_reg || dev_rst ||
                        (state_reg == ST_CONFIG) || (state_reg == ST_HALT);
      outputs_enable <= !pll_power_down_reg && !dev_rst && (state_reg == ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // read-only registers have no write path
  function automatic logic [7:0] read_mux(input logic [7:0] addr);
    case (addr)
      OFS_PRODUCT_IDENTIFIER:   read_mux = PRODUCT_ID_VALUE;
      OFS_MASK_REVISION:        read_mux = MASK_REV_VALUE;
      OFS_SERIAL_SLAVE_ADDRESS: read_mux = {slave_hi_reg, slave_lo_reg, 1'b0};
      OFS_IMAGE_REVISION:       read_mux = image_rev_reg;
      OFS_DEVICE_CONTROL:       read_mux = {1'b0, pll_power_down_reg, dc_spare_reg,
                                            cal_trigger_reg, auto_start_reg};
      default:                  read_mux = 8'h00;
    endcase
  endfunction

  // Read data holds until the next read; valid marks the answer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rsp <= '0;
    end else begin
      reg_rsp.valid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rsp.rdata <= read_mux(reg_req.addr);
      end
    end
  end

endmodule // oscreg_top

`default_nettype wire

// ===== dv/oscreg_checker.sv
// Port-level assertions for the oscillator register bank.
// Assumes a bind onto oscreg_top, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module oscreg_checker
  import oscreg_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire oscreg_req_t reg_req,
  input wire oscreg_rsp_t reg_rsp,
  input wire logic        pll_locked,
  input wire logic        pll_enable,
  input wire logic        pll_reset,
  input wire logic        cal_start,
  input wire logic        outputs_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_rd(logic [7:0] a);
    reg_req.rd && reg_req.addr == a;
  endsequence
  sequence s_ctl_wr;
    reg_req.wr && reg_req.addr == OFS_DEVICE_CONTROL;
  endsequence
  // Power-down bit as last written; a device reset keeps it
  logic pdn_wr_reg;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pdn_wr_reg <= 1'b0;
    end else if (reg_req.wr && reg_req.addr == OFS_DEVICE_CONTROL) begin
      pdn_wr_reg <= reg_req.wdata[DC_PLL_POWER_DOWN_BIT];
    end
  end
  rsp_valid_a: assert property (reg_req.rd |=> reg_rsp.valid)
    else $error("read not answered");
  rsp_idle_a: assert property (!reg_req.rd |=> !reg_rsp.valid)
    else $error("answer without read");
  prod_id_a: assert property (s_rd(OFS_PRODUCT_IDENTIFIER) |=> reg_rsp.rdata == PRODUCT_ID_VALUE)
    else $error("product id wrong");
  mask_rev_a: assert property (s_rd(OFS_MASK_REVISION) |=> reg_rsp.rdata == MASK_REV_VALUE)
    else $error("mask revision wrong");
  addr_lsb_a: assert property (s_rd(OFS_SERIAL_SLAVE_ADDRESS) |=> !reg_rsp.rdata[0])
    else $error("address bit 0 set");
  start_cal_a: assert property ($fell(sys_rst) |-> ##[0:2] cal_start)
    else $error("no calibration after reset");
  pdn_off_a: assert property (s_ctl_wr ##0 reg_req.wdata[6] |=> ##[0:1]
    (!pll_enable && pll_reset && !outputs_enable)) else $error("power down ignored");
  relaunch_a: assert property (outputs_enable ##0 s_ctl_wr ##0
    (reg_req.wdata[1] && !reg_req.wdata[6]) |=> cal_start) else $error("trigger ignored");
  wake_a: assert property (pll_reset && !cal_start && !pdn_wr_reg ##0 s_ctl_wr ##0
    (!reg_req.wdata[6] && reg_req.wdata[0]) |=> cal_start) else $error("no restart");
  pdn_wake_a: assert property (pdn_wr_reg ##0 s_ctl_wr ##0 !reg_req.wdata[6]
    |=> ##1 cal_start) else $error("no recalibration after power-up");
  cal_pulse_a: assert property (cal_start |=> !cal_start)
    else $error("calibration launch too long");
  lock_first_a: assert property ($rose(outputs_enable) |-> $past(pll_locked))
    else $error("outputs before lock");
endmodule // oscreg_checker
`default_nettype wire

// ===== dv/oscreg_host.sv
// Serial host stand-in issuing byte register requests.
// Assumes the caller waits; requests launch on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module oscreg_host
  import oscreg_pkg::*;
(
  input  wire logic        core_clk,
  output var  oscreg_req_t reg_req,
  input  wire oscreg_rsp_t reg_rsp
);
  initial reg_req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk);
    // Released lines flip so stale values never match
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge core_clk);
    d = reg_rsp.valid ? reg_rsp.rdata : 8'hXX;
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
  endtask
endmodule // oscreg_host
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for oscreg_top with a host and PLL stand-in.
// Assumes a 20 MHz core clock; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import oscreg_pkg::*;
  logic        core_clk, sys_rst, reset_pin_n, addr_pin_high, addr_pin_float;
  logic [4:0]  nvm_slave_addr_hi;
  logic [7:0]  nvm_image_rev, d;
  logic        nvm_commit_done, pll_cal_done, pll_locked, cal_ok = 1'b0;
  logic        pll_enable, pll_reset, cal_start, outputs_enable;
  oscreg_req_t reg_req;
  oscreg_rsp_t reg_rsp;
  int          n_fail = 0, checks_done = 0, cyc = 0, cal_cnt = 0, ctl = 1, lo = 0;
  logic [7:0]  addrs [6] = '{8'h02, 8'h03, 8'h08, 8'h09, 8'h0A, 8'h05};
  oscreg_top DUT (.core_clk(core_clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
    .addr_pin_high(addr_pin_high), .addr_pin_float(addr_pin_float), .reg_req(reg_req),
    .reg_rsp(reg_rsp), .nvm_slave_addr_hi(nvm_slave_addr_hi), .nvm_image_rev(nvm_image_rev),
    .nvm_commit_done(nvm_commit_done), .pll_cal_done(pll_cal_done), .pll_locked(pll_locked),
    .pll_enable(pll_enable), .pll_reset(pll_reset), .cal_start(cal_start),
    .outputs_enable(outputs_enable));
  oscreg_host host (.core_clk(core_clk), .reg_req(reg_req), .reg_rsp(reg_rsp));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // PLL stand-in: random calibration time, lock only while enabled
  always @(negedge core_clk) begin
    if (cal_start) cal_cnt <= 2 + $urandom_range(8);
    else if (cal_cnt > 0) cal_cnt <= cal_cnt - 1;
    pll_cal_done <= (cal_cnt == 1) && !cal_start;
    cal_ok <= (cal_ok || cal_cnt == 1) && !cal_start && !pll_reset;
    pll_locked <= cal_ok && pll_enable && !pll_reset;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  function automatic logic [7:0] expect_rd(input logic [7:0] a);
    case (a)
      OFS_PRODUCT_IDENTIFIER:   return PRODUCT_ID_VALUE;
      OFS_MASK_REVISION:        return MASK_REV_VALUE;
      OFS_SERIAL_SLAVE_ADDRESS: return {nvm_slave_addr_hi, 2'(lo), 1'b0};
      OFS_IMAGE_REVISION:       return nvm_image_rev;
      OFS_DEVICE_CONTROL:       return 8'(ctl);
      default:                  return 8'h00;
    endcase
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] want);
    checks_done++;
    if (got !== want) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a);
    host.rd(a, d);
    check(d, expect_rd(a));
  endtask
  task automatic wait_out(input logic v);
    for (int i = 0; i < 300 && outputs_enable !== v; i++) @(negedge core_clk);
    check({7'h00, outputs_enable}, {7'h00, v});
  endtask
  task automatic complete_run();
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    sys_rst = 1'b1;
    reset_pin_n = 1'b1;
    addr_pin_high = 1'b0;
    addr_pin_float = 1'b0;
    nvm_commit_done = 1'b0;
    void'($urandom(75355));
    nvm_slave_addr_hi = 5'($urandom);
    nvm_image_rev = 8'($urandom);
    repeat (4) @(negedge core_clk);
    sys_rst = 1'b0;
    wait_out(1'b1);
    for (int i = 0; i < 6; i++) begin
      rd_chk(addrs[i]);
      if (i != 4) host.wr(addrs[i], 8'($urandom));
      rd_chk(addrs[i]);
    end
    for (int k = 0; k < 3; k++) begin
      addr_pin_float = (k == 1);
      addr_pin_high = (k == 2);
      lo = (k == 2) ? 3 : k;
      nvm_slave_addr_hi = 5'($urandom);
      nvm_image_rev = 8'($urandom);
      repeat (8) @(negedge core_clk);
      reset_pin_n = 1'b0;
      repeat (8) @(negedge core_clk);
      reset_pin_n = 1'b1;
      wait_out(1'b1);
      rd_chk(OFS_SERIAL_SLAVE_ADDRESS);
      rd_chk(OFS_IMAGE_REVISION);
    end
    nvm_image_rev = 8'($urandom);
    @(negedge core_clk) nvm_commit_done = 1'b1;
    @(negedge core_clk) nvm_commit_done = 1'b0;
    rd_chk(OFS_IMAGE_REVISION);
    ctl = 3 | (int'($urandom) & 'h3C);
    host.wr(OFS_DEVICE_CONTROL, 8'(ctl));
    rd_chk(OFS_DEVICE_CONTROL);
    ctl = ctl & 'h3D;
    repeat (14) @(negedge core_clk);
    rd_chk(OFS_DEVICE_CONTROL);
    wait_out(1'b1);
    ctl = ctl | 'h40;
    host.wr(OFS_DEVICE_CONTROL, 8'(ctl));
    @(negedge core_clk);
    check({6'h00, pll_enable, pll_reset}, 8'h01);
    rd_chk(OFS_DEVICE_CONTROL);
    ctl = ctl & 'h3D;
    host.wr(OFS_DEVICE_CONTROL, 8'(ctl));
    wait_out(1'b1);
    ctl = ctl & 'h3C;
    host.wr(OFS_DEVICE_CONTROL, 8'(ctl));
    host.wr(OFS_SOFTWARE_RESET, 8'h02);
    repeat (20) @(negedge core_clk);
    check({6'h00, outputs_enable, pll_reset}, 8'h01);
    ctl = ctl | 1;
    host.wr(OFS_DEVICE_CONTROL, 8'(ctl));
    wait_out(1'b1);
    rd_chk(OFS_DEVICE_CONTROL);
    complete_run();
  end
endmodule // tb
bind oscreg_top oscreg_checker u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .reg_req(reg_req), .reg_rsp(reg_rsp), .pll_locked(pll_locked), .pll_enable(pll_enable),
  .pll_reset(pll_reset), .cal_start(cal_start), .outputs_enable(outputs_enable));
`default_nettype wire
